/* File: host_bus_model.sv */
// two-wire bus host model: start, stop, byte transfers, register access
// assumes a pull-up on sda outside; scl is driven, sda only pulled low
`timescale 1ns/100ps
module host_bus_model
  import lane_cfg_pkg::*;
#(
  parameter int         HALF = 10,
  parameter logic [6:0] DEV  = DEV_ADDR_DEFAULT
)
(
  // clock
  input  wire logic core_clk,
  // bus lines
  input  wire logic sda_line,
  output      logic scl,
  output      logic sda_low
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic half();
    repeat (HALF) @(posedge core_clk);
  endtask

  // sda moves only mid-low, well clear of the slave's synchroniser delay
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
    half();
  endtask

  task automatic start_cond();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask

  task automatic stop_cond();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                         output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ak, nak);
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic [2:0] n;
    start_cond();
    byte_io({dev, 1'b0}, 1'b1, rx, n[2]);
    byte_io(ptr, 1'b1, rx, n[1]);
    byte_io(d, 1'b1, rx, n[0]);
    stop_cond();
    ok = (n === 3'b000);
  endtask

  // single byte read, closed with a not-acknowledge
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] rx;
    logic       n;
    start_cond();
    byte_io({DEV, 1'b0}, 1'b1, rx, n);
    byte_io(ptr, 1'b1, rx, n);
    start_cond();
    byte_io({DEV, 1'b1}, 1'b1, rx, n);
    byte_io(8'hff, 1'b1, d, n);
    stop_cond();
  endtask
endmodule

/* File: lane_cfg_pkg.sv */
// constants for the lane drive and receive equaliser register slice
// assumes byte-wide registers behind a two-wire management bus slave
package lane_cfg_pkg;

  // register offsets
  localparam logic [7:0] ADDR_LANE2_DRV = 8'h34;
  localparam logic [7:0] ADDR_RSVD_A    = 8'h35;
  localparam logic [7:0] ADDR_RSVD_B    = 8'h4d;
  localparam logic [7:0] ADDR_EQ_L1L2   = 8'h4e;
  localparam logic [7:0] ADDR_EQ_CLKL0  = 8'h4f;

  // field positions in the lane-2 drive register
  localparam int SWING_MSB = 7;
  localparam int SWING_LSB = 5;
  localparam int PRE_MSB   = 4;
  localparam int PRE_LSB   = 3;
  localparam int SPARE_MSB = 2;
  localparam int SPARE_LSB = 0;

  // field positions in the equaliser registers
  localparam int EQ_HI_MSB = 7;
  localparam int EQ_HI_LSB = 4;
  localparam int EQ_LO_MSB = 3;
  localparam int EQ_LO_LSB = 0;

  // values after reset
  localparam logic [7:0] RST_LANE2_DRV = 8'h00;
  localparam logic [7:0] RST_EQ_L1L2   = 8'h00;
  localparam logic [7:0] RST_EQ_CLKL0  = 8'h00;
  localparam logic [7:0] RSVD_VALUE    = 8'h00;
  localparam logic [7:0] RST_PTR       = 8'h00;

  // pre-emphasis codes
  localparam logic [1:0] PRE_NONE = 2'h0;
  localparam logic [1:0] PRE_RSVD = 2'h3;

  // serial bus bit counts per byte
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // device address on the management bus, value arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2c;

endpackage

/* File: lane_drive_eq_config.sv */
// lane-2 drive and per-lane receive equaliser registers with mode gating
// assumes mode, override, swap and global settings come from other logic
// on core_clk; oe_pin and the strap pins are raw pins.
//
// Overview of operation
// RULE1: bits 7:5 give lane-2 output_swing step
// RULE2: bits 4:3 give lane-2 pre-emphasis, 11 reserved
// RULE3: per-lane fields apply only with override set; override gates lane-2 drive fields only, not equaliser fields
// RULE4: default mode ignores pre-emphasis writes, clock none
// RULE5: per-lane registers honoured only in alternate_redriver_mode
// RULE6: bits 2:0 spare, writable, no effect
// RULE7: locations 35h and 4Dh read zero
// RULE8: 4Eh holds lane-1 and lane-2 equaliser codes
// RULE9: 4Fh holds clock and lane-0 equaliser codes
// RULE10: input lane order can be swapped
// RULE11: host changes oe only after supplies settle
// RULE12: configuration from bus, or straps without bus
// RULE13: alternate_redriver_mode forces bus-only global configuration
// RULE14: power-down or oe rise clears all registers
// RULE15: writes to reserved locations silently ignored
`timescale 1ns/100ps
module lane_drive_eq_config
  import lane_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // management bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe,
  // power control
  input  wire logic        oe_pin,
  input  wire logic        power_down_entry,
  // straps
  input  wire logic        bus_config_pin,
  input  wire logic [3:0]  strap_eq_pin,
  // mode bits from the mode register
  input  wire logic        alternate_redriver_mode,
  input  wire logic        lane_override,
  input  wire logic        lane_swap,
  // global settings
  input  wire logic [2:0]  global_output_swing,
  input  wire logic [1:0]  global_preemph,
  input  wire logic [3:0]  global_eq,
  // settings to the analog lanes
  output      logic [2:0]  d2_output_swing,
  output      logic [1:0]  d2_preemph,
  output      logic [1:0]  clk_preemph,
  output      logic [15:0] rx_eq
);

  typedef struct packed {
    logic        oe1;
    logic        oe2;
    logic        oe3;
    logic        bus1;
    logic        bus2;
    logic [3:0]  strap1;
    logic [3:0]  strap2;
    logic [7:0]  drv;
    logic [7:0]  eq_a;
    logic [7:0]  eq_b;
    logic [2:0]  swing;
    logic [1:0]  pre;
    logic [1:0]  clk_pre;
    logic [15:0] eq_out;
  } cfg_t;

  // reserved code is not trusted by the driver, so it drives no boost
  function automatic logic [1:0] fix_pre(input logic [1:0] code);
    fix_pre = (code == PRE_RSVD) ? PRE_NONE : code;
  endfunction

  // reverse the four input lanes, nibble 0 is the clock pin
  function automatic logic [15:0] swap_lanes(input logic [15:0] eq);
    swap_lanes = {eq[3:0], eq[7:4], eq[11:8], eq[15:12]};
  endfunction

  cfg_t        q;
  cfg_t        d;
  logic        clr;
  logic        use_lane;
  logic        bus_cfg;
  logic [3:0]  base_eq;
  logic [15:0] lane_eq;

  reg_port_if rp ();

  mgmt_bus_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_bus (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .rp       (rp)
  );

  always_comb
  begin
    d        = q;
    // oe is only trusted once supplies settle, so no debounce here
    d.oe1    = oe_pin; // RULE11
    d.oe2    = q.oe1;
    d.oe3    = q.oe2;
    d.bus1   = bus_config_pin;
    d.bus2   = q.bus1;
    d.strap1 = strap_eq_pin;
    d.strap2 = q.strap1;
    clr      = power_down_entry | ~q.oe2 | (q.oe2 & ~q.oe3); // RULE14
    use_lane = alternate_redriver_mode & lane_override; // RULE3
    bus_cfg  = alternate_redriver_mode | q.bus2; // RULE13
    base_eq  = bus_cfg ? global_eq : q.strap2; // RULE12

    if (clr)
    begin
      d.drv  = RST_LANE2_DRV; // RULE14
      d.eq_a = RST_EQ_L1L2;
      d.eq_b = RST_EQ_CLKL0;
    end
    else if (rp.wr_en)
    begin
      case (rp.addr)
        ADDR_LANE2_DRV:
        begin
          d.drv[SWING_MSB:SWING_LSB] = rp.wr_data[SWING_MSB:SWING_LSB]; // RULE1
          d.drv[SPARE_MSB:SPARE_LSB] = rp.wr_data[SPARE_MSB:SPARE_LSB]; // RULE6
          if (alternate_redriver_mode)
            d.drv[PRE_MSB:PRE_LSB] = rp.wr_data[PRE_MSB:PRE_LSB]; // RULE4
        end
        ADDR_EQ_L1L2:  d.eq_a = rp.wr_data; // RULE8
        ADDR_EQ_CLKL0: d.eq_b = rp.wr_data; // RULE9
        default:       d.drv  = q.drv; // RULE15
      endcase
    end

    d.swing = use_lane ? q.drv[SWING_MSB:SWING_LSB] : global_output_swing; // RULE1
    d.pre   = fix_pre(use_lane ? q.drv[PRE_MSB:PRE_LSB] : global_preemph); // RULE2
    d.clk_pre = alternate_redriver_mode ? fix_pre(global_preemph) : PRE_NONE; // RULE4

    if (alternate_redriver_mode) // RULE5
      lane_eq = {q.eq_a[EQ_LO_MSB:EQ_LO_LSB], q.eq_a[EQ_HI_MSB:EQ_HI_LSB],
                 q.eq_b[EQ_LO_MSB:EQ_LO_LSB], q.eq_b[EQ_HI_MSB:EQ_HI_LSB]};
    else
      lane_eq = {4{base_eq}};
    d.eq_out = lane_swap ? swap_lanes(lane_eq) : lane_eq; // RULE10
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  always_comb
  begin
    case (rp.addr)
      ADDR_LANE2_DRV: rp.rd_data = q.drv;
      ADDR_EQ_L1L2:   rp.rd_data = q.eq_a;
      ADDR_EQ_CLKL0:  rp.rd_data = q.eq_b;
      default:        rp.rd_data = RSVD_VALUE; // RULE7
    endcase
  end

  assign d2_output_swing = q.swing;
  assign d2_preemph      = q.pre;
  assign clk_preemph     = q.clk_pre;
  assign rx_eq           = q.eq_out;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_swing_lane: assert property ( // RULE1
    use_lane |=> d2_output_swing == $past(q.drv[SWING_MSB:SWING_LSB]))
    else $error("lane-2 swing does not follow its field");

  a_pre_lane: assert property ( // RULE2
    use_lane && q.drv[PRE_MSB:PRE_LSB] != PRE_RSVD
    |=> d2_preemph == $past(q.drv[PRE_MSB:PRE_LSB]))
    else $error("lane-2 pre-emphasis does not follow its field");

  a_global_follow: assert property ( // RULE3
    rst_n && !lane_override |=> d2_output_swing == $past(global_output_swing)
                       && d2_preemph == fix_pre($past(global_preemph)))
    else $error("lanes not on global settings without override");

  a_pre_locked: assert property ( // RULE4
    rp.wr_en && rp.addr == ADDR_LANE2_DRV && !alternate_redriver_mode && !clr
    |=> q.drv[PRE_MSB:PRE_LSB] == $past(q.drv[PRE_MSB:PRE_LSB]))
    else $error("pre-emphasis write taken in default mode");

  a_clk_no_pre: assert property ( // RULE4
    !alternate_redriver_mode |=> clk_preemph == PRE_NONE)
    else $error("clock lane pre-emphasis in default mode");

  a_eq_honour: assert property ( // RULE5
    rst_n && !alternate_redriver_mode |=> rx_eq == {4{$past(base_eq)}})
    else $error("per-lane equaliser used outside alternate mode");

  a_spare_bits: assert property ( // RULE6
    rp.wr_en && rp.addr == ADDR_LANE2_DRV && !clr ##1 !clr && !rp.wr_en
    |=> q.drv[SPARE_MSB:SPARE_LSB] == $past(rp.wr_data[SPARE_MSB:SPARE_LSB], 2))
    else $error("spare bits not stored");

  a_rsvd_read: assert property ( // RULE7
    rp.addr == ADDR_RSVD_A || rp.addr == ADDR_RSVD_B |-> rp.rd_data == RSVD_VALUE)
    else $error("reserved location reads nonzero");

  a_eq_l1l2: assert property ( // RULE8
    rp.wr_en && rp.addr == ADDR_EQ_L1L2 && !clr
    |=> q.eq_a == $past(rp.wr_data) ##0 rp.addr != ADDR_EQ_L1L2 || rp.rd_data == q.eq_a)
    else $error("lane-1/2 equaliser write lost");

  a_eq_clkl0: assert property ( // RULE9
    rp.wr_en && rp.addr == ADDR_EQ_CLKL0 && !clr |=> q.eq_b == $past(rp.wr_data))
    else $error("clock/lane-0 equaliser write lost");

  a_lane_swap: assert property ( // RULE10
    alternate_redriver_mode && lane_swap
    |=> rx_eq[3:0] == $past(q.eq_a[EQ_LO_MSB:EQ_LO_LSB])
        && rx_eq[15:12] == $past(q.eq_b[EQ_HI_MSB:EQ_HI_LSB]))
    else $error("swapped lane order wrong");

  a_strap_route: assert property ( // RULE12
    !alternate_redriver_mode && !q.bus2 |=> rx_eq[3:0] == $past(q.strap2))
    else $error("strap equaliser not used without bus");

  a_bus_only: assert property ( // RULE13
    alternate_redriver_mode && !lane_override
    |=> d2_output_swing == $past(global_output_swing) && rx_eq != {4{$past(q.strap2)}}
        || $past(q.eq_a) == {2{$past(q.strap2)}})
    else $error("straps used in alternate mode");

  a_clear_oe: assert property ( // RULE14
    q.oe2 && !q.oe3 |=> q.drv == RST_LANE2_DRV && q.eq_a == RST_EQ_L1L2
                        && q.eq_b == RST_EQ_CLKL0)
    else $error("registers not cleared on oe rise");

  a_rsvd_write: assert property ( // RULE15
    rp.wr_en && (rp.addr == ADDR_RSVD_A || rp.addr == ADDR_RSVD_B) && !clr
    |=> $stable(q.drv) && $stable(q.eq_a) && $stable(q.eq_b))
    else $error("reserved write changed state");

  // outputs lag one cycle, so output checks compare with last cycle's inputs; readback checks use the same cycle
  a_pre_rsvd_none: assert property ( // RULE2
    rst_n && use_lane && q.drv[PRE_MSB:PRE_LSB] == PRE_RSVD |=> d2_preemph == PRE_NONE)
    else $error("reserved pre-emphasis code drives a boost");

  a_power_clear: assert property ( // RULE14
    power_down_entry |=> q.drv == RST_LANE2_DRV && q.eq_a == RST_EQ_L1L2
                         && q.eq_b == RST_EQ_CLKL0)
    else $error("registers not cleared on power-down");

  a_oe_low_clear: assert property ( // RULE14
    !q.oe2 |=> q.drv == RST_LANE2_DRV && q.eq_a == RST_EQ_L1L2
               && q.eq_b == RST_EQ_CLKL0)
    else $error("registers not held clear while oe low");

  a_swing_default: assert property ( // RULE5
    rst_n && !alternate_redriver_mode |=> d2_output_swing == $past(global_output_swing))
    else $error("lane-2 swing register used outside alternate mode");

  a_clk_global: assert property ( // RULE13
    rst_n && alternate_redriver_mode |=> clk_preemph == fix_pre($past(global_preemph)))
    else $error("clock lane not on global pre-emphasis in alternate mode");

  a_drv_read: assert property ( // RULE6
    rp.addr == ADDR_LANE2_DRV |-> rp.rd_data == q.drv)
    else $error("lane-2 drive register reads back wrong");

  a_clkl0_read: assert property ( // RULE9
    rp.addr == ADDR_EQ_CLKL0 |-> rp.rd_data == q.eq_b)
    else $error("clock/lane-0 equaliser reads back wrong");

  // nothing but a bus write or a clear may move the stored settings
  a_drv_hold: assert property ( // RULE1
    rst_n && !clr && !rp.wr_en |=> $stable(q.drv))
    else $error("lane-2 drive register changed with no write");

  a_eq_hold: assert property ( // RULE8
    rst_n && !clr && !rp.wr_en |=> $stable(q.eq_a) && $stable(q.eq_b))
    else $error("equaliser registers changed with no write");

  c_lane_write: cover property (
    use_lane && rp.wr_en && rp.addr == ADDR_LANE2_DRV ##2 d2_output_swing != 3'h0);

  c_oe_rise: cover property (!q.oe2 ##1 q.oe2 ##1 !clr);

  c_swap_eq: cover property (alternate_redriver_mode && lane_swap && rx_eq != 16'h0000);

  c_pre_rsvd: cover property (use_lane && q.drv[PRE_MSB:PRE_LSB] == PRE_RSVD);

  c_strap_eq: cover property (
    !alternate_redriver_mode && !q.bus2 ##2 rx_eq == {4{q.strap2}});

endmodule

/* File: mgmt_bus_slave.sv */
// two-wire management bus slave with an auto-incrementing register pointer
// assumes scl and sda come straight from pins; no clock stretching
`timescale 1ns/100ps
module mgmt_bus_slave
  import lane_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // bus pins, sda is open drain
  input  wire logic scl_in,
  input  wire logic sda_in,
  output      logic sda_out,
  output      logic sda_oe,
  // register side
  reg_port_if.slave rp
);

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_PTR, ST_WR, ST_RD} bus_st_t;

  typedef struct packed {
    bus_st_t    st;
    logic       scl1;
    logic       scl2;
    logic       scl3;
    logic       sda1;
    logic       sda2;
    logic       sda3;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       rw;
    logic       nack;
    logic [7:0] ptr;
    logic       oe;
    logic       wr;
    logic [7:0] wd;
  } slave_t;

  slave_t q;
  slave_t d;
  logic   rise;
  logic   fall;

  always_comb
  begin
    d      = q;
    d.wr   = 1'b0;
    d.scl1 = scl_in;
    d.scl2 = q.scl1;
    d.scl3 = q.scl2;
    d.sda1 = sda_in;
    d.sda2 = q.sda1;
    d.sda3 = q.sda2;
    rise   = q.scl2 & ~q.scl3;
    fall   = ~q.scl2 & q.scl3;
    if (q.scl2 && q.scl3 && q.sda3 && !q.sda2)
    begin
      d.st  = ST_DEV;
      d.cnt = 4'h0;
      d.oe  = 1'b0;
    end
    else if (q.scl2 && q.scl3 && !q.sda3 && q.sda2)
    begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
    end
    else if (q.st != ST_IDLE && rise)
    begin
      if (q.st != ST_RD && q.cnt < BIT_ACK)
        d.sh = {q.sh[6:0], q.sda2};
      if (q.st == ST_RD && q.cnt == BIT_ACK)
        d.nack = q.sda2;
      d.cnt = q.cnt + 4'h1;
    end
    else if (q.st != ST_IDLE && fall)
    begin
      if (q.cnt == BIT_ACK)
      begin
        case (q.st)
          ST_DEV:
          begin
            if (q.sh[7:1] == DEV_ADDR)
            begin
              d.oe = 1'b1;
              d.rw = q.sh[0];
            end
            else
              d.st = ST_IDLE;
          end
          ST_PTR:  d.oe = 1'b1;
          ST_WR:
          begin
            d.oe = 1'b1;
            d.wr = 1'b1;
            d.wd = q.sh;
          end
          ST_RD:
          begin
            d.oe  = 1'b0;
            d.ptr = q.ptr + 8'h01;
          end
          default: d.st = ST_IDLE;
        endcase
      end
      else if (q.cnt == BIT_END)
      begin
        d.cnt = 4'h0;
        d.oe  = 1'b0;
        case (q.st)
          ST_DEV:
          begin
            if (q.rw)
            begin
              d.st = ST_RD;
              d.sh = rp.rd_data;
              d.oe = ~rp.rd_data[7];
            end
            else
              d.st = ST_PTR;
          end
          ST_PTR:
          begin
            d.ptr = q.sh;
            d.st  = ST_WR;
          end
          ST_WR:   d.ptr = q.ptr + 8'h01;
          ST_RD:
          begin
            // a master nack ends the read burst
            if (q.nack)
              d.st = ST_IDLE;
            else
            begin
              d.sh = rp.rd_data;
              d.oe = ~rp.rd_data[7];
            end
          end
          default: d.st = ST_IDLE;
        endcase
      end
      else if (q.st == ST_RD)
      begin
        d.sh = {q.sh[6:0], 1'b0};
        d.oe = ~q.sh[6];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign sda_out    = 1'b0;
  assign sda_oe     = q.oe;
  assign rp.wr_en   = q.wr;
  assign rp.addr    = q.ptr;
  assign rp.wr_data = q.wd;

endmodule

/* File: reg_port_if.sv */
// byte register port between the bus slave and the register slice
// assumes both ends run on the same register clock
`timescale 1ns/100ps
interface reg_port_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  modport slave
  (
    output wr_en,
    output addr,
    output wr_data,
    input  rd_data
  );

  modport regs
  (
    input  wr_en,
    input  addr,
    input  wr_data,
    output rd_data
  );
endinterface

/* File: test_lane_drive_eq_config.sv */
// self-checking bench for the lane drive and equaliser register slice
// assumes host_bus_model as bus host and a pulled-up data line
`timescale 1ns/100ps
module test_lane_drive_eq_config;
  import lane_cfg_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        oe_pin = 1'b0;
  logic        power_down_entry = 1'b0;
  logic        bus_config_pin = 1'b1;
  logic [3:0]  strap_eq_pin = 4'h9;
  logic        alternate_redriver_mode = 1'b0;
  logic        lane_override = 1'b0;
  logic        lane_swap = 1'b0;
  logic [2:0]  global_output_swing = 3'h5;
  logic [1:0]  global_preemph = 2'h2;
  logic [3:0]  global_eq = 4'h6;
  logic        scl, sda_low, sda_out, sda_oe, sda_line, ok;
  logic [2:0]  d2_output_swing;
  logic [1:0]  d2_preemph, clk_preemph;
  logic [15:0] rx_eq;
  logic [7:0]  rd, v;
  int          n_mismatch = 0;
  int          comparisons = 0;
  localparam logic [7:0] AL [5] = '{ADDR_LANE2_DRV, ADDR_RSVD_A, ADDR_RSVD_B,
                                    ADDR_EQ_L1L2, ADDR_EQ_CLKL0};

  always #20 core_clk = ~core_clk;
  assign sda_line = ~((sda_oe & ~sda_out) | sda_low);

  lane_drive_eq_config lane_drive_eq_config_inst
  (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .oe_pin(oe_pin),
    .power_down_entry(power_down_entry), .bus_config_pin(bus_config_pin),
    .strap_eq_pin(strap_eq_pin), .alternate_redriver_mode(alternate_redriver_mode),
    .lane_override(lane_override), .lane_swap(lane_swap),
    .global_output_swing(global_output_swing), .global_preemph(global_preemph),
    .global_eq(global_eq), .d2_output_swing(d2_output_swing),
    .d2_preemph(d2_preemph), .clk_preemph(clk_preemph), .rx_eq(rx_eq)
  );

  host_bus_model host_bus_model_inst
  (
    .core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    host_bus_model_inst.read_reg(a, rd);
    check(16'(rd), 16'(exp), "readback");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_bus_model_inst.write_reg(DEV_ADDR_DEFAULT, a, d, ok);
    check(16'(ok), 16'h1, "write ack");
  endtask

  task automatic set_in(input logic alt, input logic ovr, input logic swp);
    @(posedge core_clk);
    alternate_redriver_mode <= alt;
    lane_override <= ovr;
    lane_swap <= swp;
    repeat (3) @(posedge core_clk);
  endtask

  // expected lane settings from the mode inputs and the stored registers
  task automatic check_outs(input logic [7:0] drv, input logic [7:0] e4e,
                            input logic [7:0] e4f);
    logic        sel;
    logic [1:0]  p;
    logic [3:0]  b;
    logic [15:0] q;
    sel = alternate_redriver_mode & lane_override;
    p = sel ? drv[4:3] : global_preemph;
    b = bus_config_pin ? global_eq : strap_eq_pin;
    q = alternate_redriver_mode ? {e4e[3:0], e4e[7:4], e4f[3:0], e4f[7:4]} : {4{b}};
    if (lane_swap)
      q = {q[3:0], q[7:4], q[11:8], q[15:12]};
    check(16'(d2_output_swing), 16'(sel ? drv[7:5] : global_output_swing), "swing");
    check(16'(d2_preemph), 16'((p == 2'h3) ? 2'h0 : p), "pre-emphasis");
    check(16'(clk_preemph), 16'(alternate_redriver_mode ? global_preemph : 2'h0), "clk");
    check(rx_eq, q, "equaliser");
  endtask

  initial
  begin
    repeat (95000) @(posedge core_clk);
    n_mismatch++;
    $display("mismatch at %0t: run too long", $time);
    give_verdict();
  end

  initial
  begin
    repeat (2) @(posedge core_clk);
    oe_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    for (int i = 0; i < 5; i++)
      rd_check(AL[i], 8'h00);
    check_outs(8'h00, 8'h00, 8'h00);
    $display("reset values done");
    set_in(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      v = {3'(i), 2'(i), 3'(~i)};
      wr(ADDR_LANE2_DRV, v);
      check_outs(v, 8'h00, 8'h00);
      rd_check(ADDR_LANE2_DRV, v);
    end
    set_in(1'b1, 1'b0, 1'b0);
    check_outs(8'hf8, 8'h00, 8'h00);
    $display("lane-2 drive codes done");
    set_in(1'b0, 1'b1, 1'b0);
    // pre-emphasis bits keep 11 from the last write above
    wr(ADDR_LANE2_DRV, 8'h52);
    rd_check(ADDR_LANE2_DRV, 8'h5a);
    check_outs(8'h5a, 8'h00, 8'h00);
    bus_config_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    check_outs(8'h5a, 8'h00, 8'h00);
    bus_config_pin <= 1'b1;
    $display("default mode done");
    set_in(1'b1, 1'b0, 1'b0);
    wr(ADDR_EQ_L1L2, 8'h3c);
    wr(ADDR_EQ_CLKL0, 8'ha5);
    check_outs(8'h5a, 8'h3c, 8'ha5);
    rd_check(ADDR_EQ_L1L2, 8'h3c);
    rd_check(ADDR_EQ_CLKL0, 8'ha5);
    set_in(1'b1, 1'b0, 1'b1);
    check_outs(8'h5a, 8'h3c, 8'ha5);
    $display("equaliser done");
    wr(ADDR_RSVD_A, 8'hff);
    wr(ADDR_RSVD_B, 8'hff);
    rd_check(ADDR_RSVD_A, 8'h00);
    rd_check(ADDR_RSVD_B, 8'h00);
    rd_check(ADDR_LANE2_DRV, 8'h5a);
    host_bus_model_inst.write_reg(DEV_ADDR_DEFAULT ^ 7'h01, ADDR_LANE2_DRV, 8'h00, ok);
    check(16'(ok), 16'h0, "foreign address acked");
    rd_check(ADDR_LANE2_DRV, 8'h5a);
    $display("reserved and refused writes done");
    @(posedge core_clk);
    power_down_entry <= 1'b1;
    @(posedge core_clk);
    power_down_entry <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd_check(ADDR_LANE2_DRV, 8'h00);
    rd_check(ADDR_EQ_L1L2, 8'h00);
    wr(ADDR_EQ_CLKL0, 8'ha5);
    rd_check(ADDR_EQ_CLKL0, 8'ha5);
    oe_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    oe_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd_check(ADDR_EQ_CLKL0, 8'h00);
    check_outs(8'h00, 8'h00, 8'h00);
    $display("clear on power-down and enable done");
    give_verdict();
  end
endmodule
